// file: hw/option_cfg_pkg.sv
// Constants shared by the configuration byte store and its decoder.
// Assumes a single 10 MHz core clock and an active-low async reset.

package option_cfg_pkg;

    // ==========================================================
    // Byte selection and stored values
    localparam logic       SEL_BYTE0      = 1'b0;
    localparam logic       SEL_BYTE1      = 1'b1;
    localparam logic [7:0] BYTE0_SHIPPED  = 8'hFC;
    localparam logic [7:0] BYTE1_SHIPPED  = 8'hEF;
    localparam logic [7:0] ERASED_VALUE   = 8'hFF;

    // ==========================================================
    // Field positions, byte zero
    localparam int SECTOR_HI_POS  = 3;
    localparam int SECTOR_LO_POS  = 2;
    localparam int READOUT_POS    = 1;
    localparam int WRPROT_POS     = 0;

    // ==========================================================
    // Field positions, byte one
    localparam int FACTOR_POS     = 7;
    localparam int MULT_OFF_POS   = 6;
    localparam int OSC_POS        = 4;
    localparam int SUPPLY_HI_POS  = 3;
    localparam int SUPPLY_LO_POS  = 2;
    localparam int GUARD_SOFT_POS = 1;
    localparam int GUARD_HALT_POS = 0;

    // ==========================================================
    // Decoded values
    localparam logic [10:0] SECTOR_HALF_K  = 11'h200;
    localparam logic [10:0] SECTOR_ONE_K   = 11'h400;
    localparam logic [10:0] SECTOR_1P5_K   = 11'h600;
    localparam logic [1:0]  SUPPLY_CODE_OFF = 2'h3;
    localparam logic [1:0]  SUPPLY_CODE_HI  = 2'h2;
    localparam logic [1:0]  SUPPLY_CODE_MID = 2'h1;
    localparam logic [1:0]  LEVEL_LOW       = 2'h0;
    localparam logic [1:0]  LEVEL_MID       = 2'h1;
    localparam logic [1:0]  LEVEL_HIGH      = 2'h2;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        IDLE,
        WIPE,
        ERASE_CFG
    } seq_state_t;

endpackage : option_cfg_pkg

// file: hw/nv_byte_cell.sv
// One non-volatile configuration byte.
// Assumes por_n only falls on power-up; system reset leaves the content alone.
`timescale 1ns/1ps
`default_nettype none

module nv_byte_cell #(
    parameter logic [7:0] SHIPPED = 8'hFF
) (
    input  wire logic       core_clk,
    input  wire logic       por_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output var  logic [7:0] stored
);

    // ==========================================================
    // Storage
    // Content survives resetn; only the power-on strobe restores it
    always_ff @(posedge core_clk or negedge por_n) begin
        if (!por_n) begin
            stored <= SHIPPED;
        end else if (wr_en) begin
            stored <= wr_data;
        end
    end

endmodule : nv_byte_cell

`default_nettype wire

// file: hw/option_byte_config_decoder.sv
// Configuration byte store, programming access and settings decoder.
// Assumes mode and request inputs come from logic on core_clk, and that
// the memory wipe engine answers a held request with a done pulse.
`timescale 1ns/1ps
`default_nettype none

module option_byte_config_decoder
    import option_cfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        por_n,
    // Mode status
    input  wire logic        prog_mode,
    input  wire logic        user_mode,
    input  wire logic        in_application_programming,
    // Programming tool access
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_erase,
    input  wire logic        cfg_sel,
    input  wire logic [7:0]  cfg_wdata,
    output var  logic [7:0]  cfg_rdata,
    output logic             cfg_ack,
    output logic             cfg_err,
    output logic             cfg_busy,
    // Whole-memory wipe engine
    output var  logic        mem_wipe_req,
    input  wire logic        mem_wipe_done,
    // Protection unit
    output var  logic [10:0] first_sector_size,
    output var  logic        readout_protect,
    output var  logic        program_write_protect,
    output logic             mem_access_block,
    output logic             mem_write_allow,
    // Clock management
    output var  logic        multiplier_factor_sel,
    output var  logic        multiplier_disable,
    output var  logic        rc_osc_enable,
    output var  logic        ext_clock_sel,
    // Supply supervisor
    output var  logic        supply_detector_enable,
    output var  logic [1:0]  supply_threshold_sel,
    // Watchdog
    output var  logic        guard_timer_soft_enable,
    output var  logic        guard_timer_hw_enable,
    output var  logic        guard_timer_reset_on_halt,
    input  wire logic        halt_entry,
    input  wire logic        guard_timer_active,
    output var  logic        halt_reset_req,
    output var  logic        settings_valid
);

    // ==========================================================
    // Non-volatile bytes
    logic [7:0]  nv_byte0;
    logic [7:0]  nv_byte1;
    logic        wr_byte0;
    logic        wr_byte1;
    logic [7:0]  wdata0;
    logic [7:0]  wdata1;
    seq_state_t  state;
    logic        nv_wp;
    logic        nv_rp;
    logic        req_any;
    logic        refuse;

    nv_byte_cell #(
        .SHIPPED (BYTE0_SHIPPED)
    ) u_byte0 (
        .core_clk (core_clk),
        .por_n    (por_n),
        .wr_en    (wr_byte0),
        .wr_data  (wdata0),
        .stored   (nv_byte0)
    );

    nv_byte_cell #(
        .SHIPPED (BYTE1_SHIPPED)
    ) u_byte1 (
        .core_clk (core_clk),
        .por_n    (por_n),
        .wr_en    (wr_byte1),
        .wr_data  (wdata1),
        .stored   (nv_byte1)
    );

    // Live protection bits, so a change applies to later requests
    assign nv_wp = nv_byte0[WRPROT_POS];
    assign nv_rp = nv_byte0[READOUT_POS];

    // ==========================================================
    // Request screening
    assign req_any  = cfg_rd | cfg_wr | cfg_erase;
    assign cfg_busy = (state != IDLE);

    // Outside programming mode everything is refused; a write to byte
    // zero under write protection is refused as it would touch the bit
    always_comb begin
        refuse = 1'b0;
        if (!prog_mode) begin
            refuse = 1'b1;
        end else if (cfg_wr && cfg_sel == SEL_BYTE0 && nv_wp) begin
            refuse = 1'b1;
        end
    end

    // ==========================================================
    // Erase sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE: begin
                    if (cfg_erase && !refuse) begin
                        if (nv_rp) begin
                            state <= WIPE;
                        end else begin
                            state <= ERASE_CFG;
                        end
                    end
                end
                WIPE: begin
                    if (mem_wipe_done) begin
                        state <= ERASE_CFG;
                    end
                end
                ERASE_CFG: begin
                    state <= IDLE;
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mem_wipe_req <= 1'b0;
        end else if (state == WIPE && mem_wipe_done) begin
            mem_wipe_req <= 1'b0;
        end else if (state == IDLE && cfg_erase && !refuse && nv_rp) begin
            mem_wipe_req <= 1'b1;
        end
    end

    // ==========================================================
    // Write strobes into the cells
    // Requests while busy are ignored and answered with no ack
    always_comb begin
        wr_byte0 = 1'b0;
        wr_byte1 = 1'b0;
        wdata0   = cfg_wdata;
        wdata1   = cfg_wdata;
        if (state == ERASE_CFG) begin
            wdata0   = ERASED_VALUE;
            wdata1   = ERASED_VALUE;
            wr_byte0 = !nv_wp;
            wr_byte1 = 1'b1;
        end else if (state == IDLE && cfg_wr && !cfg_erase && !refuse) begin
            wr_byte0 = (cfg_sel == SEL_BYTE0);
            wr_byte1 = (cfg_sel == SEL_BYTE1);
        end
    end

    // ==========================================================
    // Answers to the tool
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_ack <= 1'b0;
            cfg_err <= 1'b0;
        end else begin
            cfg_ack <= 1'b0;
            cfg_err <= 1'b0;
            if (state == ERASE_CFG) begin
                cfg_ack <= 1'b1;
            end else if (state == IDLE && req_any) begin
                if (refuse) begin
                    cfg_err <= 1'b1;
                end else if (!cfg_erase) begin
                    cfg_ack <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata <= 8'h00;
        end else if (state == IDLE && cfg_rd && !cfg_wr && !cfg_erase
                     && prog_mode) begin
            cfg_rdata <= (cfg_sel == SEL_BYTE0) ? nv_byte0 : nv_byte1;
        end
    end

    // ==========================================================
    // Latch at reset
    // Async reset may only load constants, so the shipped values stand
    // during reset and the stored bytes are taken on the first edge
    logic       load_done;
    logic [7:0] cfg0;
    logic [7:0] cfg1;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            load_done <= 1'b0;
            cfg0      <= BYTE0_SHIPPED;
            cfg1      <= BYTE1_SHIPPED;
        end else if (!load_done) begin
            load_done <= 1'b1;
            cfg0      <= nv_byte0;
            cfg1      <= nv_byte1;
        end
    end

    assign settings_valid = load_done;

    // ==========================================================
    // Decoded settings, registered from the latched bytes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            first_sector_size <= SECTOR_1P5_K;
            readout_protect   <= 1'b0;
            program_write_protect <= 1'b0;
        end else begin
            if (cfg0[SECTOR_HI_POS]) begin
                first_sector_size <= SECTOR_1P5_K;
            end else if (cfg0[SECTOR_LO_POS]) begin
                first_sector_size <= SECTOR_ONE_K;
            end else begin
                first_sector_size <= SECTOR_HALF_K;
            end
            readout_protect       <= cfg0[READOUT_POS];
            program_write_protect <= cfg0[WRPROT_POS];
        end
    end

    // Write protection follows the live bit so it bites at once
    assign mem_write_allow  = !nv_wp && !program_write_protect;
    assign mem_access_block = readout_protect
                              && !(user_mode || in_application_programming);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            multiplier_factor_sel <= 1'b1;
            multiplier_disable    <= 1'b1;
            rc_osc_enable         <= 1'b1;
            ext_clock_sel         <= 1'b0;
        end else begin
            multiplier_factor_sel <= cfg1[FACTOR_POS];
            multiplier_disable    <= cfg1[MULT_OFF_POS];
            rc_osc_enable         <= !cfg1[OSC_POS];
            ext_clock_sel         <= cfg1[OSC_POS];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            supply_detector_enable <= 1'b0;
            supply_threshold_sel   <= LEVEL_LOW;
        end else begin
            supply_detector_enable <=
                (cfg1[SUPPLY_HI_POS:SUPPLY_LO_POS] != SUPPLY_CODE_OFF);
            case (cfg1[SUPPLY_HI_POS:SUPPLY_LO_POS])
                SUPPLY_CODE_HI:  supply_threshold_sel <= LEVEL_HIGH;
                SUPPLY_CODE_MID: supply_threshold_sel <= LEVEL_MID;
                default:         supply_threshold_sel <= LEVEL_LOW;
            endcase
        end
    end

    // ==========================================================
    // Watchdog settings and halt reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            guard_timer_soft_enable   <= 1'b1;
            guard_timer_hw_enable     <= 1'b0;
            guard_timer_reset_on_halt <= 1'b1;
        end else begin
            guard_timer_soft_enable   <= cfg1[GUARD_SOFT_POS];
            guard_timer_hw_enable     <= !cfg1[GUARD_SOFT_POS];
            guard_timer_reset_on_halt <= cfg1[GUARD_HALT_POS];
        end
    end

    // A hardware-enabled watchdog counts as active even if the unit lags
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            halt_reset_req <= 1'b0;
        end else begin
            halt_reset_req <= halt_entry && guard_timer_reset_on_halt
                && (guard_timer_active || guard_timer_hw_enable);
        end
    end

endmodule : option_byte_config_decoder

`default_nettype wire

// file: tb/wipe_engine_model.sv
// Behavioural memory wipe engine on the far side of the decoder.
// Assumes the decoder holds its wipe request until it sees done.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Wipe engine
module wipe_engine_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       mem_wipe_req,
    input  wire logic [3:0] wipe_delay,
    output var  logic       mem_wipe_done
);
    logic [3:0] wait_cnt;
    // Delay set by the bench; the only wipe it runs gets a slow answer, with a delay of 8
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt      <= 4'h0;
            mem_wipe_done <= 1'b0;
        end else begin
            mem_wipe_done <= mem_wipe_req && !mem_wipe_done
                && wait_cnt == wipe_delay;
            wait_cnt <= (mem_wipe_req && !mem_wipe_done) ?
                wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : wipe_engine_model
`default_nettype wire

// file: tb/option_cfg_assertions.sv
// Port checker for the configuration decoder, bound to its top.
// Assumes one clock, core_clk, and the async resetn.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module option_cfg_checker (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        prog_mode,
    input wire logic        user_mode,
    input wire logic        in_application_programming,
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic        cfg_erase,
    input wire logic        cfg_ack,
    input wire logic        cfg_err,
    input wire logic        cfg_busy,
    input wire logic        mem_wipe_req,
    input wire logic        mem_wipe_done,
    input wire logic [10:0] first_sector_size,
    input wire logic        readout_protect,
    input wire logic        mem_access_block,
    input wire logic        rc_osc_enable,
    input wire logic        ext_clock_sel,
    input wire logic        guard_timer_soft_enable,
    input wire logic        guard_timer_hw_enable,
    input wire logic        guard_timer_reset_on_halt,
    input wire logic        halt_entry,
    input wire logic        guard_timer_active,
    input wire logic        halt_reset_req,
    input wire logic        settings_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence refused_req_s;
        settings_valid && !cfg_busy && !prog_mode
            && (cfg_rd || cfg_wr || cfg_erase);
    endsequence
    sequence halt_cause_s;
        halt_entry && guard_timer_reset_on_halt
            && (guard_timer_active || guard_timer_hw_enable);
    endsequence
    access_gate_a: assert property (
        mem_access_block == (readout_protect && !(user_mode
        || in_application_programming))) else $error("bad access block");
    osc_pair_a: assert property (
        rc_osc_enable != ext_clock_sel) else $error("bad clock source");
    guard_pair_a: assert property (
        guard_timer_soft_enable != guard_timer_hw_enable)
        else $error("bad watchdog type");
    mode_refuse_a: assert property (
        refused_req_s |=> cfg_err) else $error("request not refused");
    halt_reset_a: assert property (
        halt_cause_s |=> halt_reset_req) else $error("no halt reset");
    wipe_hold_a: assert property (
        mem_wipe_req && !mem_wipe_done |=> mem_wipe_req)
        else $error("wipe request dropped");
    wipe_then_ack_a: assert property (
        $fell(mem_wipe_req) |-> ##[1:2] cfg_ack)
        else $error("no ack after wipe");
    settings_hold_a: assert property (
        settings_valid && $past(settings_valid, 2)
        |-> $stable({first_sector_size, rc_osc_enable}))
        else $error("settings moved");
endmodule : option_cfg_checker
bind option_byte_config_decoder option_cfg_checker u_chk (
    .core_clk(core_clk), .resetn(resetn), .prog_mode(prog_mode),
    .user_mode(user_mode), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .in_application_programming(in_application_programming),
    .cfg_erase(cfg_erase), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
    .cfg_busy(cfg_busy), .mem_wipe_req(mem_wipe_req),
    .mem_wipe_done(mem_wipe_done), .first_sector_size(first_sector_size),
    .readout_protect(readout_protect), .mem_access_block(mem_access_block),
    .rc_osc_enable(rc_osc_enable), .ext_clock_sel(ext_clock_sel),
    .guard_timer_soft_enable(guard_timer_soft_enable),
    .guard_timer_hw_enable(guard_timer_hw_enable),
    .guard_timer_reset_on_halt(guard_timer_reset_on_halt),
    .halt_entry(halt_entry), .guard_timer_active(guard_timer_active),
    .halt_reset_req(halt_reset_req), .settings_valid(settings_valid)
);
`default_nettype wire

// file: tb/tb_option_byte_config_decoder.sv
// Self-checking bench for the configuration decoder.
// Assumes the wipe engine model sits on the wipe handshake.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module tb_option_byte_config_decoder
    import option_cfg_pkg::*;
;
    localparam logic [2:0] RD = 3'h1;
    localparam logic [2:0] WR = 3'h2;
    localparam logic [2:0] ER = 3'h4;
    logic        core_clk, resetn, por_n, prog_mode, user_mode;
    logic        in_application_programming, cfg_rd, cfg_wr, cfg_erase;
    logic        cfg_sel, mem_wipe_done, halt_entry, guard_timer_active;
    logic [7:0]  cfg_wdata, cfg_rdata;
    logic        cfg_ack, cfg_err, cfg_busy, mem_wipe_req;
    logic [10:0] first_sector_size;
    logic        readout_protect, program_write_protect, mem_access_block;
    logic        mem_write_allow, multiplier_factor_sel, multiplier_disable;
    logic        rc_osc_enable, ext_clock_sel, supply_detector_enable;
    logic [1:0]  supply_threshold_sel;
    logic        guard_timer_soft_enable, guard_timer_hw_enable;
    logic        guard_timer_reset_on_halt, halt_reset_req, settings_valid;
    logic [3:0]  wipe_delay;
    logic [15:0] lfsr_q;
    logic [22:0] settings;
    logic [9:0]  exp_q[$];
    int          miscompares = 0;
    int          num_checks = 0;

    option_byte_config_decoder dut (
        .core_clk(core_clk), .resetn(resetn), .por_n(por_n),
        .prog_mode(prog_mode), .user_mode(user_mode),
        .in_application_programming(in_application_programming),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_erase(cfg_erase),
        .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .cfg_err(cfg_err), .cfg_busy(cfg_busy),
        .mem_wipe_req(mem_wipe_req), .mem_wipe_done(mem_wipe_done),
        .first_sector_size(first_sector_size),
        .readout_protect(readout_protect),
        .program_write_protect(program_write_protect),
        .mem_access_block(mem_access_block),
        .mem_write_allow(mem_write_allow),
        .multiplier_factor_sel(multiplier_factor_sel),
        .multiplier_disable(multiplier_disable),
        .rc_osc_enable(rc_osc_enable), .ext_clock_sel(ext_clock_sel),
        .supply_detector_enable(supply_detector_enable),
        .supply_threshold_sel(supply_threshold_sel),
        .guard_timer_soft_enable(guard_timer_soft_enable),
        .guard_timer_hw_enable(guard_timer_hw_enable),
        .guard_timer_reset_on_halt(guard_timer_reset_on_halt),
        .halt_entry(halt_entry), .guard_timer_active(guard_timer_active),
        .halt_reset_req(halt_reset_req), .settings_valid(settings_valid)
    );
    wipe_engine_model partner (
        .core_clk(core_clk), .resetn(resetn), .mem_wipe_req(mem_wipe_req),
        .wipe_delay(wipe_delay), .mem_wipe_done(mem_wipe_done)
    );
    assign settings = {first_sector_size, readout_protect,
        program_write_protect, multiplier_factor_sel, multiplier_disable,
        rc_osc_enable, ext_clock_sel, supply_detector_enable,
        supply_threshold_sel, guard_timer_soft_enable,
        guard_timer_hw_enable, guard_timer_reset_on_halt};

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [22:0] decode(input logic [7:0] b0,
                                           input logic [7:0] b1);
        logic [10:0] sec;
        logic [1:0]  thr;
        sec = b0[3] ? 11'h600 : (b0[2] ? 11'h400 : 11'h200);
        thr = (b1[3:2] == 2'h3) ? 2'h0 : b1[3:2];
        return {sec, b0[1:0], b1[7:6], !b1[4], b1[4], b1[3:2] != 2'h3,
            thr, b1[1], !b1[1], b1[0]};
    endfunction : decode

    task automatic end_sim();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic chk_set(input logic [22:0] got, input logic [22:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_set

    task automatic chk_rsp(input logic [8:0] got, input logic [8:0] exp);
        chk_set(23'(got), 23'(exp));
    endtask : chk_rsp

    // Note layout: refused flag, read flag, read data
    task automatic req(input logic [2:0] kind, input logic sel,
                       input logic [7:0] d, input logic [9:0] note);
        int n;
        @(negedge core_clk);
        {cfg_erase, cfg_wr, cfg_rd} = kind;
        cfg_sel = sel;
        cfg_wdata = d;
        exp_q.push_back(note);
        @(negedge core_clk);
        {cfg_erase, cfg_wr, cfg_rd} = 3'h0;
        if (kind == ER && !note[9]) chk_set(23'(cfg_busy), 23'h1);
        for (n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge core_clk);
        if (exp_q.size() != 0) begin
            miscompares++;
            end_sim();
        end
        @(negedge core_clk);
    endtask : req

    task automatic do_rst(input logic por);
        @(negedge core_clk);
        resetn = 1'b0;
        por_n = !por;
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        por_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_set(23'(settings_valid), 23'h1);
    endtask : do_rst

    // Responses stand one cycle, so the falling edge always sees them
    always @(negedge core_clk) begin
        logic [9:0] note;
        if (cfg_ack === 1'b1 || cfg_err === 1'b1) begin
            note = exp_q.size() != 0 ? exp_q.pop_front() : 10'h3FF;
            chk_rsp({cfg_err, note[8] ? cfg_rdata : 8'h00},
                    {note[9], note[8] ? note[7:0] : 8'h00});
        end
    end

    initial begin
        int         i;
        logic [7:0] b0, b1;
        {resetn, por_n, prog_mode, user_mode} = 4'h0;
        {in_application_programming, cfg_rd, cfg_wr, cfg_erase} = 4'h0;
        {cfg_sel, halt_entry, guard_timer_active} = 3'h0;
        cfg_wdata = 8'h00;
        wipe_delay = 4'h0;
        lfsr_q = 16'hA4DD;
        do_rst(1'b1);
        chk_set(settings, decode(BYTE0_SHIPPED, BYTE1_SHIPPED));
        req(RD, SEL_BYTE0, 8'h00, 10'h200);
        req(WR, SEL_BYTE1, 8'h20, 10'h200);
        prog_mode = 1'b1;
        req(RD, SEL_BYTE0, 8'h00, {2'h1, BYTE0_SHIPPED});
        req(RD, SEL_BYTE1, 8'h00, {2'h1, BYTE1_SHIPPED});
        $display("test shipped done");
        for (i = 0; i < 4; i++) begin
            lfsr_q = lfsr(lfsr_q);
            b0 = {4'hF, i[1:0], i == 3, 1'b0};
            b1 = {lfsr_q[7:6], 1'b1, lfsr_q[4], i[1:0], lfsr_q[1:0]};
            req(WR, SEL_BYTE0, b0, 10'h000);
            req(WR, SEL_BYTE1, b1, 10'h000);
            do_rst(1'b0);
            chk_set(settings, decode(b0, b1));
            req(RD, SEL_BYTE1, 8'h00, {2'h1, b1});
        end
        for (i = 0; i < 4; i++) begin
            @(negedge core_clk);
            {user_mode, in_application_programming} = i[1:0];
            #10 chk_set(23'(mem_access_block), 23'(i == 0));
        end
        {user_mode, in_application_programming} = 2'h0;
        $display("test decode done");
        wipe_delay = lfsr_q[3:0];
        req(ER, SEL_BYTE0, 8'h00, 10'h000);
        req(RD, SEL_BYTE0, 8'h00, {2'h1, ERASED_VALUE});
        $display("test erase done");
        // Erased byte zero reads as write protected; power-on restores it
        do_rst(1'b1);
        req(WR, SEL_BYTE0, 8'hF1, 10'h000);
        req(WR, SEL_BYTE1, 8'hA9, 10'h000);
        do_rst(1'b0);
        chk_set(settings, decode(8'hF1, 8'hA9));
        chk_set(23'(mem_write_allow), 23'h0);
        req(WR, SEL_BYTE0, 8'hF0, 10'h200);
        req(ER, SEL_BYTE0, 8'h00, 10'h000);
        req(RD, SEL_BYTE0, 8'h00, {2'h1, 8'hF1});
        halt_entry = 1'b1;
        @(negedge core_clk);
        halt_entry = 1'b0;
        chk_set(23'(halt_reset_req), 23'h1);
        $display("test protect done");
        end_sim();
    end
endmodule : tb_option_byte_config_decoder
`default_nettype wire
